// ### hdl/software_upset_guard.sv
/*
  One-time-enabled watchdog with reset-out, as seen from inside the
  microcontroller's special-function register bus.
  Assumes clk is the oscillator itself; power_down high means the
  oscillator is stopped, so the block stops counting, holds any reset pulse and blocks arming while it is high.
  The special-function bus gives a one-cycle write or read strobe with
  an address and data, synchronous to clk.
*/

module software_upset_guard
  import wdog_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_we,
  input  wire logic       sfr_re,
  input  wire logic       power_down,
  input  wire logic       idle_mode,
  input  wire logic       wake_int_n,
  output logic [7:0]      sfr_rdata,
  output logic            sfr_rvalid,
  output logic            rst_pin_out,
  output logic            rst_pin_oe,
  output logic            dog_enabled
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  dog_state_e                 state;
  dog_state_e                 next_state;
  seq_state_e                 seq;
  seq_state_e                 next_seq;
  logic [DOG_WIDTH-1:0]       count;
  logic [DOG_WIDTH-1:0]       next_count;
  logic [3:0]                 prescale;
  logic [3:0]                 next_prescale;
  logic [6:0]                 pulse_cnt;
  logic [6:0]                 next_pulse_cnt;
  logic                       idle_halt_select;
  logic                       next_idle_halt_select;
  logic                       wake_hold;
  logic                       next_wake_hold;
  logic [7:0]                 next_sfr_rdata;
  logic                       next_sfr_rvalid;
  logic                       next_rst_pin;
  logic                       next_dog_enabled;

  logic                       svc_write;
  logic                       svc_done;
  logic                       mc_tick;
  logic                       count_ok;

  // Auxiliary control image as software reads it back
  function automatic logic [7:0] aux_image(input logic halt);
    logic [7:0] img;
    img                = 8'h00;
    img[IDLE_HALT_BIT] = halt;
    return img;
  endfunction : aux_image

  // ------------------------------------------------------------------
  // Service sequence detector
  // ------------------------------------------------------------------
  assign svc_write = sfr_we && (sfr_addr == SERVICE_ADDR);

  // Pair completes only on second byte as the next service-address write after first byte
  always_comb begin
    next_seq = seq;
    svc_done = 1'b0;
    if (svc_write) begin
      case (seq)
        SEQ_WAIT_FIRST: begin
          if (sfr_wdata == SERVICE_FIRST) begin
            next_seq = SEQ_WAIT_SECOND;
          end
        end
        SEQ_WAIT_SECOND: begin
          if (sfr_wdata == SERVICE_SECOND) begin
            svc_done = 1'b1;
            next_seq = SEQ_WAIT_FIRST;
          end else if (sfr_wdata == SERVICE_FIRST) begin
            next_seq = SEQ_WAIT_SECOND;  // Fresh first byte
          end else begin
            next_seq = SEQ_WAIT_FIRST;
          end
        end
        default: begin
          next_seq = SEQ_WAIT_FIRST;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Register access: auxiliary control and read-back
  // ------------------------------------------------------------------
  always_comb begin
    next_idle_halt_select = idle_halt_select;
    next_sfr_rdata        = 8'h00;
    next_sfr_rvalid       = 1'b0;
    if (sfr_we && (sfr_addr == AUX_CTRL_ADDR)) begin
      next_idle_halt_select = sfr_wdata[IDLE_HALT_BIT];
    end
    if (sfr_re) begin
      next_sfr_rvalid = 1'b1;
      if (sfr_addr == AUX_CTRL_ADDR) begin
        next_sfr_rdata = aux_image(idle_halt_select);
      end else begin
        next_sfr_rdata = 8'h00;
      end
    end
  end

  // ------------------------------------------------------------------
  // Machine-cycle divider and wake-up hold
  // ------------------------------------------------------------------
  always_comb begin
    next_prescale  = prescale;
    mc_tick        = 1'b0;
    next_wake_hold = wake_hold;
    if (power_down) begin
      next_wake_hold = 1'b1;
    end else begin
      if (wake_int_n) begin
        next_wake_hold = 1'b0;
      end
      if (prescale == MC_LAST) begin
        next_prescale = MC_ZERO;
        mc_tick       = 1'b1;
      end else begin
        next_prescale = prescale + 4'h1;
      end
    end
  end

  // Counting allowed: running, oscillator on, not held, idle permits
  assign count_ok = mc_tick && !wake_hold
                 && !(idle_mode && idle_halt_select);

  // ------------------------------------------------------------------
  // Watchdog state, counter and reset-out pulse
  // ------------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_count       = count;
    next_pulse_cnt   = pulse_cnt;
    next_rst_pin     = 1'b0;
    next_dog_enabled = 1'b0;
    case (state)
      DOG_OFF: begin
        if (svc_done && !power_down) begin
          next_state       = DOG_RUN;
          next_count       = DOG_ZERO;
          next_dog_enabled = 1'b1;
        end
      end
      DOG_RUN: begin
        next_dog_enabled = 1'b1;
        if (svc_done) begin
          next_count = DOG_ZERO;
        end else if (count_ok) begin
          if (count == DOG_TOP) begin
            next_state       = DOG_PULSE;
            next_pulse_cnt   = PULSE_ZERO;
            next_rst_pin     = 1'b1;
            next_dog_enabled = 1'b0;
          end else begin
            next_count = count + 13'h0001;
          end
        end
      end
      DOG_PULSE: begin
        if (!power_down) begin
          if (pulse_cnt == PULSE_LAST) begin
            next_state = DOG_OFF;
            next_count = DOG_ZERO;
          end else begin
            next_pulse_cnt = pulse_cnt + 7'h01;
            next_rst_pin   = 1'b1;
          end
        end else begin
          next_rst_pin = 1'b1;
        end
      end
      default: begin
        next_state = DOG_OFF;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state            <= DOG_OFF;
      seq              <= SEQ_WAIT_FIRST;
      count            <= DOG_ZERO;
      prescale         <= MC_ZERO;
      pulse_cnt        <= PULSE_ZERO;
      idle_halt_select <= IDLE_HALT_RST;
      wake_hold        <= 1'b0;
      sfr_rdata        <= 8'h00;
      sfr_rvalid       <= 1'b0;
      rst_pin_out      <= 1'b0;
      rst_pin_oe       <= 1'b0;
      dog_enabled      <= 1'b0;
    end else begin
      state            <= next_state;
      seq              <= next_seq;
      count            <= next_count;
      prescale         <= next_prescale;
      pulse_cnt        <= next_pulse_cnt;
      idle_halt_select <= next_idle_halt_select;
      wake_hold        <= next_wake_hold;
      sfr_rdata        <= next_sfr_rdata;
      sfr_rvalid       <= next_sfr_rvalid;
      rst_pin_out      <= next_rst_pin;
      rst_pin_oe       <= next_rst_pin;
      dog_enabled      <= next_dog_enabled;
    end
  end

endmodule : software_upset_guard

// ### hdl/wdog_pkg.sv
/*
  Constants for the one-time-enabled watchdog: special-function addresses,
  service bytes, counter widths, timing figures and state encodings.
  Assumes a single oscillator clock that is also the block's clock.
*/
package wdog_pkg;

  // ------------------------------------------------------------------
  // Special-function register map
  // ------------------------------------------------------------------
  localparam logic [7:0] SERVICE_ADDR   = 8'ha6;  // Write-only service
  localparam logic [7:0] AUX_CTRL_ADDR  = 8'h8e;  // Auxiliary control
  localparam int         IDLE_HALT_BIT  = 4;      // Idle-halt select
  localparam logic       IDLE_HALT_RST  = 1'h0;   // Counts in idle

  // ------------------------------------------------------------------
  // Service sequence bytes
  // ------------------------------------------------------------------
  localparam logic [7:0] SERVICE_FIRST  = 8'h1e;
  localparam logic [7:0] SERVICE_SECOND = 8'he1;

  // ------------------------------------------------------------------
  // Counter and timing
  // ------------------------------------------------------------------
  localparam int          DOG_WIDTH     = 13;
  localparam logic [12:0] DOG_TOP       = 13'h1fff;
  localparam logic [12:0] DOG_ZERO      = 13'h0000;
  localparam int          OSC_PER_MC    = 12;     // Oscillator periods
  localparam logic [3:0]  MC_LAST       = 4'(OSC_PER_MC - 1);
  localparam logic [3:0]  MC_ZERO       = 4'h0;
  localparam int          OSC_PERIOD_NS = 40;     // 25 MHz oscillator
  localparam int          PULSE_OSC     = 96;     // Reset pulse length
  localparam int          PULSE_NS      = PULSE_OSC * OSC_PERIOD_NS;
  localparam int          PULSE_CYC     = PULSE_NS / OSC_PERIOD_NS;
  localparam logic [6:0]  PULSE_LAST    = 7'(PULSE_CYC - 1);
  localparam logic [6:0]  PULSE_ZERO    = 7'h00;

  // ------------------------------------------------------------------
  // State encodings (Gray along off -> run -> pulse)
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    DOG_OFF   = 2'h0,
    DOG_RUN   = 2'h1,
    DOG_PULSE = 2'h3
  } dog_state_e;

  typedef enum logic {
    SEQ_WAIT_FIRST  = 1'h0,
    SEQ_WAIT_SECOND = 1'h1
  } seq_state_e;

endpackage : wdog_pkg

// ### dv/wdog_check_properties.sv
/*
  Checker for the watchdog's strobes, arming and reset-out pulse.
  Assumes it is bound to software_upset_guard on the oscillator clock.
*/
module wdog_check
  import wdog_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_we,
  input wire logic       sfr_re,
  input wire logic       power_down,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_rvalid,
  input wire logic       rst_pin_out,
  input wire logic       rst_pin_oe,
  input wire logic       dog_enabled
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Pulse length counter and service byte decode
  // ----------------------------------------------------------------
  logic [7:0] hi_cnt;
  logic [7:0] next_hi_cnt;
  logic       wr_one;
  logic       wr_two;
  // Counts high cycles, frozen while the oscillator is stopped
  always_comb begin
    next_hi_cnt = rst_pin_out ? hi_cnt + 8'h01 : 8'h00;
    if (power_down) next_hi_cnt = hi_cnt;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hi_cnt <= 8'h00;
    else hi_cnt <= next_hi_cnt;
  end
  assign wr_one = sfr_we && sfr_addr == SERVICE_ADDR
                  && sfr_wdata == SERVICE_FIRST;
  assign wr_two = sfr_we && sfr_addr == SERVICE_ADDR
                  && sfr_wdata == SERVICE_SECOND;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_reset_off: assert property ($rose(resetn) |-> !dog_enabled)
    else $error("armed right after reset");
  a_arm_pair: assert property (wr_two && $past(wr_one) && !dog_enabled
    && !rst_pin_out && !power_down |=> dog_enabled)
    else $error("pair did not arm");
  a_arm_cause: assert property (!dog_enabled && !wr_two
    |=> !dog_enabled)
    else $error("armed without second byte");
  a_stay_on: assert property (dog_enabled
    |=> dog_enabled || rst_pin_out)
    else $error("disarmed without overflow");
  a_pulse_cause: assert property ($rose(rst_pin_out)
    |-> $past(dog_enabled))
    else $error("pulse while not armed");
  a_pulse_len: assert property ($fell(rst_pin_out) |-> hi_cnt == 8'h60)
    else $error("pulse length wrong");
  a_pulse_max: assert property (rst_pin_out |-> hi_cnt < 8'h60)
    else $error("pulse too long");
  a_pin_mirror: assert property (rst_pin_oe == rst_pin_out)
    else $error("pin enable differs");
  a_read_strobe: assert property (sfr_rvalid == $past(sfr_re))
    else $error("read valid misplaced");
  a_write_only: assert property (sfr_re && sfr_addr != AUX_CTRL_ADDR
    |=> sfr_rdata == 8'h00)
    else $error("nonzero read data");
  a_aux_bits: assert property (sfr_rvalid
    |-> (sfr_rdata & 8'hef) == 8'h00)
    else $error("reserved bits set");
endmodule : wdog_check

bind software_upset_guard wdog_check chk_u (.clk(clk), .resetn(resetn),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
  .sfr_re(sfr_re), .power_down(power_down), .sfr_rdata(sfr_rdata),
  .sfr_rvalid(sfr_rvalid), .rst_pin_out(rst_pin_out),
  .rst_pin_oe(rst_pin_oe), .dog_enabled(dog_enabled));

// ### dv/tb_top.sv
/*
  Self-checking bench: reads, arming, servicing, sleep modes, overflow.
  Assumes the checker binds itself to the design from its own file.
*/
module tb_top
  import wdog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        resetn, we, re, pd, idle, wake_n, rv, rpo, en;
  logic [7:0]  addr, wdata, rdata;
  logic [7:0]  q[$];
  logic [31:0] seed = 32'hb5df09a5;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          t0;
  // Oscillator and cycle count
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  software_upset_guard dut_u (.clk(clk), .resetn(resetn), .sfr_addr(addr),
    .sfr_wdata(wdata), .sfr_we(we), .sfr_re(re), .power_down(pd),
    .idle_mode(idle), .wake_int_n(wake_n), .sfr_rdata(rdata),
    .sfr_rvalid(rv), .rst_pin_out(rpo), .rst_pin_oe(), .dog_enabled(en));
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_num(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: %0d cycles", $time, got);
    end
  endtask : chk_num
  // Bus drivers; wr keeps the strobe up so pairs run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    wdata = d;
  endtask : wr
  task automatic stop();
    @(negedge clk);
    we = 1'b0;
  endtask : stop
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    re = 1'b1;
    addr = a;
    q.push_back(exp);
    @(negedge clk);
    re = 1'b0;
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Read data monitor
  always @(negedge clk) begin
    if (rv === 1'b1) chk_val(rdata, q.pop_front());
  end
  // Hang guard
  initial begin
    #(105000 * 40);
    n_mismatch++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {resetn, we, re, pd, idle} = 5'h00;
    wake_n = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    rd(AUX_CTRL_ADDR, 8'h00);
    rd(SERVICE_ADDR, 8'h00);
    wr(SERVICE_ADDR, SERVICE_SECOND);
    wr(SERVICE_ADDR, SERVICE_FIRST);
    wr(SERVICE_ADDR, 8'h55);
    wr(SERVICE_ADDR, SERVICE_SECOND);
    stop();
    repeat (2) @(negedge clk);
    chk_val({7'h00, en}, 8'h00);
    wr(AUX_CTRL_ADDR, 8'h10);
    stop();
    rd(AUX_CTRL_ADDR, 8'h10);
    wr(SERVICE_ADDR, SERVICE_FIRST);
    wr(8'h90, 8'(xorshift()));
    wr(SERVICE_ADDR, SERVICE_SECOND);
    stop();
    repeat (2) @(negedge clk);
    chk_val({7'h00, en}, 8'h01);
    repeat (200 + int'(xorshift() % 100)) @(negedge clk);
    wr(SERVICE_ADDR, SERVICE_FIRST);
    wr(SERVICE_ADDR, SERVICE_SECOND);
    stop();
    t0 = cyc;
    // Frozen spans: power-down, wake hold, halted idle (500 cycles)
    wake_n = 1'b0;
    pd = 1'b1;
    repeat (200) @(negedge clk);
    pd = 1'b0;
    repeat (100) @(negedge clk);
    wake_n = 1'b1;
    idle = 1'b1;
    repeat (200) @(negedge clk);
    idle = 1'b0;
    wr(AUX_CTRL_ADDR, 8'h00);
    stop();
    idle = 1'b1;
    repeat (200) @(negedge clk);
    idle = 1'b0;
    chk_val({7'h00, en}, 8'h01);
    while (rpo !== 1'b1 && cyc - t0 < 100000) @(negedge clk);
    chk_num(cyc - t0, 98304 + 500 - 16, 98304 + 500 + 16);
    t0 = cyc;
    while (rpo === 1'b1 && cyc - t0 < 200) @(negedge clk);
    chk_num(cyc - t0, 96, 96);
    chk_val({7'h00, en}, 8'h00);
    // Re-arm after overflow with a back-to-back pair
    wr(SERVICE_ADDR, SERVICE_FIRST);
    wr(SERVICE_ADDR, SERVICE_SECOND);
    stop();
    repeat (2) @(negedge clk);
    chk_val({7'h00, en}, 8'h01);
    // Service before sleep, in the wake handler and on an idle wake-up
    wr(SERVICE_ADDR, SERVICE_FIRST);
    wr(SERVICE_ADDR, SERVICE_SECOND);
    stop();
    wake_n = 1'b0;
    pd = 1'b1;
    repeat (20) @(negedge clk);
    pd = 1'b0;
    repeat (10) @(negedge clk);
    wake_n = 1'b1;
    wr(SERVICE_ADDR, SERVICE_FIRST);
    wr(SERVICE_ADDR, SERVICE_SECOND);
    stop();
    idle = 1'b1;
    repeat (30) @(negedge clk);
    idle = 1'b0;
    wr(SERVICE_ADDR, SERVICE_FIRST);
    wr(SERVICE_ADDR, SERVICE_SECOND);
    wr(AUX_CTRL_ADDR, 8'h10);
    stop();
    idle = 1'b1;
    chk_val({7'h00, en}, 8'h01);
    // Hardware reset in mid-run disarms and clears idle-halt select
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    idle = 1'b0;
    repeat (2) @(negedge clk);
    chk_val({7'h00, en}, 8'h00);
    rd(AUX_CTRL_ADDR, 8'h00);
    repeat (2) @(negedge clk);
    give_verdict();
  end
endmodule : tb_top
